// ===== rtl/agu_pkg.sv
/*
 Package for the bit-reversed and program-space address unit.
 Holds register offsets, field positions, reset values and widths.
 Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
*/
package agu_pkg;
    localparam int DATA_W = 16;
    localparam int PROG_W = 24;
    localparam int PVIS_W = 23;
    localparam int PAGE_W = 8;
    localparam int MOD_W  = 15;
    localparam int ADDR_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_MODULO   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_REVERSE  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_TBLPAGE  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_VISPAGE  = 4'hC;

    // Field positions
    localparam int MOD_SEL_LSB = 8;
    localparam int MOD_XEN_BIT = 15;
    localparam int REV_EN_BIT  = 15;

    // Pointer select value that names the stack pointer
    localparam logic [3:0] STACK_SEL = 4'hF;

    // Addressing mode codes from operand decode
    localparam logic [2:0] MODE_DIRECT  = 3'h0;
    localparam logic [2:0] MODE_IND     = 3'h1;
    localparam logic [2:0] MODE_POSTDEC = 3'h2;
    localparam logic [2:0] MODE_POSTINC = 3'h3;
    localparam logic [2:0] MODE_PREDEC  = 3'h4;
    localparam logic [2:0] MODE_PREINC  = 3'h5;

    localparam logic [15:0] RST_MODULO  = 16'h0000;
    localparam logic [15:0] RST_REVERSE = 16'h0000;
    localparam logic [7:0]  RST_PAGE    = 8'h00;

    typedef enum logic [1:0] {AGU_IDLE, AGU_RESP} agu_bus_e;
endpackage

// ===== rtl/agu_rev_add.sv
/*
 Reverse-carry adder: adds a word-scaled modifier to a pointer with carry
 running from the most significant bit toward the least.
 Assumes purely combinational use inside the address unit.
*/
module agu_rev_add
    import agu_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic [W-1:0] ptr,
    input  wire logic [W-1:0] modif,
    output logic      [W-1:0] sum
);
    logic [W-1:0] pr;
    logic [W-1:0] mr;
    logic [W:0]   rs;

    // Mirror, add normally, mirror back: same as reversed carry flow
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            pr[i] = ptr[W-1-i];
            mr[i] = modif[W-1-i];
        end
        rs = {1'b0, pr} + {1'b0, mr};
        for (int i = 0; i < W; i++)
        begin
            sum[i] = rs[W-1-i];
        end
    end
endmodule

// ===== rtl/agu_top.sv
/*
 Address unit for bit-reversed write addressing and program-space
 address building (table page and visibility page).
 Assumes operand decode presents one request per cycle with req_valid,
 a single clock core_clk and registers reached over Avalon-MM.
*/
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
module agu_top
    import agu_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // Operand decode
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic              req_byte,
    input  wire logic [2:0]        req_mode,
    input  wire logic [3:0]        req_wreg,
    input  wire logic [DATA_W-1:0] req_ptr,
    input  wire logic              req_table,
    input  wire logic              req_hi_byte,
    // Write and read address unit results
    output logic                   wr_valid,
    output logic [DATA_W-1:0]      wr_ea,
    output logic [DATA_W-1:0]      wr_ptr_next,
    output logic                   wr_rev_active,
    output logic                   rd_modulo_en,
    // Program bus
    output logic                   prog_valid,
    output logic [PROG_W-1:0]      prog_addr,
    output logic                   prog_write,
    output logic                   prog_cfg,
    output logic                   prog_hi_byte,
    output logic                   prog_low_word,
    output logic                   prog_wr_reject
);
    typedef struct packed {
        agu_bus_e           bus;
        logic [31:0]        rdata;
        logic               wait_n;
        logic [15:0]        modulo_control_reg;
        logic [15:0]        reverse_control_reg;
        logic [PAGE_W-1:0]  table_page;
        logic [PAGE_W-1:0]  visibility_page;
        logic               wr_valid;
        logic [DATA_W-1:0]  wr_ea;
        logic [DATA_W-1:0]  wr_ptr_next;
        logic               wr_rev_active;
        logic               rd_modulo_en;
        logic               prog_valid;
        logic [PROG_W-1:0]  prog_addr;
        logic               prog_write;
        logic               prog_cfg;
        logic               prog_hi_byte;
        logic               prog_low_word;
        logic               prog_wr_reject;
    } agu_state_s;

    agu_state_s state_reg;
    agu_state_s state_next;

    logic [3:0]        reverse_pointer_select;
    logic              reverse_enable;
    logic              modulo_x_en;
    logic [MOD_W-1:0]  reverse_modifier;
    logic [DATA_W-1:0] mod_scaled;
    logic [DATA_W-1:0] rev_sum;

    function automatic logic is_inc_mode(input logic [2:0] m);
        is_inc_mode = (m == MODE_PREINC) || (m == MODE_POSTINC);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    assign reverse_pointer_select = state_reg.modulo_control_reg[MOD_SEL_LSB +: 4];
    assign modulo_x_en            = state_reg.modulo_control_reg[MOD_XEN_BIT];
    assign reverse_enable         = state_reg.reverse_control_reg[REV_EN_BIT];
    assign reverse_modifier       = state_reg.reverse_control_reg[MOD_W-1:0];
    assign mod_scaled             = {reverse_modifier, 1'b0};

    // Reverse-ordered carry within the scaled modifier field
    agu_rev_add #(.W(DATA_W)) u_rev_add
    (
        .ptr   (req_ptr),
        .modif (mod_scaled),
        .sum   (rev_sum)
    );

    always_comb
    begin
        logic        rev_mode;
        logic [15:0] step;
        logic [15:0] seq_ptr;
        logic [15:0] seq_ea;
        rev_mode   = 1'b0;
        step       = 16'h0000;
        seq_ptr    = 16'h0000;
        seq_ea     = 16'h0000;
        state_next = state_reg;

        // Bus slave: one wait cycle, answer in the second
        state_next.wait_n = 1'b0;
        case (state_reg.bus)
            AGU_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    state_next.bus    = AGU_RESP;
                    state_next.wait_n = 1'b1;
                    state_next.rdata  = 32'h0000_0000;
                    if (avs_write)
                    begin
                        case (avs_address)
                            OFS_MODULO:  state_next.modulo_control_reg =
                                             merge16(state_reg.modulo_control_reg, avs_writedata, avs_byteenable);
                            OFS_REVERSE: state_next.reverse_control_reg =
                                             merge16(state_reg.reverse_control_reg, avs_writedata, avs_byteenable);
                            OFS_TBLPAGE: if (avs_byteenable[0]) state_next.table_page = avs_writedata[7:0];
                            OFS_VISPAGE: if (avs_byteenable[0]) state_next.visibility_page = avs_writedata[7:0];
                            default:     state_next.rdata = 32'h0000_0000;
                        endcase
                    end
                    else
                    begin
                        case (avs_address)
                            OFS_MODULO:  state_next.rdata = {16'h0000, state_reg.modulo_control_reg};
                            OFS_REVERSE: state_next.rdata = {16'h0000, state_reg.reverse_control_reg};
                            OFS_TBLPAGE: state_next.rdata = {24'h000000, state_reg.table_page};
                            OFS_VISPAGE: state_next.rdata = {24'h000000, state_reg.visibility_page};
                            default:     state_next.rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            AGU_RESP:
            begin
                state_next.bus = AGU_IDLE;
            end
            default:
            begin
                state_next.bus = AGU_IDLE;
            end
        endcase

        // Write address unit
        rev_mode = (reverse_pointer_select != STACK_SEL) && reverse_enable
                   && is_inc_mode(req_mode)
                   && (req_wreg == reverse_pointer_select)
                   && req_write && !req_byte;
        step     = req_byte ? 16'h0001 : 16'h0002;
        case (req_mode)
            MODE_POSTINC, MODE_PREINC:   seq_ptr = req_ptr + step;
            MODE_POSTDEC, MODE_PREDEC:   seq_ptr = req_ptr - step;
            default:                     seq_ptr = req_ptr;
        endcase
        seq_ea = (req_mode == MODE_PREINC || req_mode == MODE_PREDEC) ? seq_ptr : req_ptr;

        state_next.wr_valid      = req_valid && req_write && !req_table;
        state_next.wr_rev_active = req_valid && rev_mode;
        if (rev_mode)
        begin
            // Pointer and result stay in normal order; modifier replaces increment
            state_next.wr_ptr_next = {rev_sum[15:1], 1'b0};
            state_next.wr_ea       = (req_mode == MODE_PREINC) ? {rev_sum[15:1], 1'b0}
                                                               : {req_ptr[15:1], 1'b0};
        end
        else
        begin
            state_next.wr_ptr_next = seq_ptr;
            state_next.wr_ea       = seq_ea;
        end
        // Modulo enable drives the read unit only: cleared on every write, reversal or not
        state_next.rd_modulo_en = modulo_x_en && req_valid && !req_write;
        if (rev_mode)
        begin
            state_next.rd_modulo_en = 1'b0;
        end

        // Program space address construction
        state_next.prog_valid     = 1'b0;
        state_next.prog_write     = 1'b0;
        state_next.prog_cfg       = 1'b0;
        state_next.prog_hi_byte   = 1'b0;
        state_next.prog_low_word  = 1'b0;
        state_next.prog_wr_reject = 1'b0;
        if (req_valid && req_table)
        begin
            state_next.prog_valid   = 1'b1;
            state_next.prog_addr    = {state_reg.table_page, req_ptr};
            state_next.prog_cfg     = state_reg.table_page[PAGE_W-1];
            state_next.prog_write   = req_write;
            state_next.prog_hi_byte = req_hi_byte;
        end
        else if (req_valid && req_ptr[DATA_W-1])
        begin
            if (req_write)
            begin
                state_next.prog_wr_reject = 1'b1;
            end
            else
            begin
                state_next.prog_valid    = 1'b1;
                state_next.prog_low_word = 1'b1;
                state_next.prog_addr     = {1'b0, state_reg.visibility_page, req_ptr[14:0]};
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg                     <= '0;
            state_reg.bus                 <= AGU_IDLE;
            state_reg.modulo_control_reg  <= RST_MODULO;
            state_reg.reverse_control_reg <= RST_REVERSE;
            state_reg.table_page          <= RST_PAGE;
            state_reg.visibility_page     <= RST_PAGE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Waitrequest high except in the answer cycle; idle low would mislead a master
    assign avs_waitrequest = !state_reg.wait_n;
    assign avs_readdata    = state_reg.rdata;
    assign wr_valid        = state_reg.wr_valid;
    assign wr_ea           = state_reg.wr_ea;
    assign wr_ptr_next     = state_reg.wr_ptr_next;
    assign wr_rev_active   = state_reg.wr_rev_active;
    assign rd_modulo_en    = state_reg.rd_modulo_en;
    assign prog_valid      = state_reg.prog_valid;
    assign prog_addr       = state_reg.prog_addr;
    assign prog_write      = state_reg.prog_write;
    assign prog_cfg        = state_reg.prog_cfg;
    assign prog_hi_byte    = state_reg.prog_hi_byte;
    assign prog_low_word   = state_reg.prog_low_word;
    assign prog_wr_reject  = state_reg.prog_wr_reject;
endmodule

// ===== verif/agu_chk_asserts.sv
/*
 Checker for the address unit, bound to agu_top.
 Assumes the top module's port names and its single clock domain.
*/
module agu_chk
    import agu_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic              req_valid,
    input wire logic              req_write,
    input wire logic              req_byte,
    input wire logic [2:0]        req_mode,
    input wire logic [DATA_W-1:0] req_ptr,
    input wire logic              req_table,
    input wire logic              req_hi_byte,
    input wire logic [DATA_W-1:0] wr_ea,
    input wire logic [DATA_W-1:0] wr_ptr_next,
    input wire logic              wr_rev_active,
    input wire logic              prog_valid,
    input wire logic [PROG_W-1:0] prog_addr,
    input wire logic              prog_write,
    input wire logic              prog_cfg,
    input wire logic              prog_hi_byte,
    input wire logic              prog_low_word,
    input wire logic              prog_wr_reject
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_REV_READ: assert property (req_valid && !req_write |=> !wr_rev_active)
        else $error("reversed update on a read");
    AST_REV_BYTE: assert property (req_valid && req_byte |=> !wr_rev_active)
        else $error("reversed update on a byte access");
    AST_REV_MODE: assert property (req_valid && req_mode != MODE_POSTINC && req_mode != MODE_PREINC |=> !wr_rev_active)
        else $error("reversed update in a non-increment mode");
    AST_REV_LSB: assert property (wr_rev_active |-> !wr_ea[0] && !wr_ptr_next[0])
        else $error("reversed address not word aligned");
    AST_REV_POST: assert property (req_valid && req_mode == MODE_POSTINC ##1 wr_rev_active |-> wr_ea == ($past(req_ptr) & 16'hFFFE))
        else $error("post-increment address is not the old pointer");
    AST_REV_PRE: assert property (req_valid && req_mode == MODE_PREINC ##1 wr_rev_active |-> wr_ea == wr_ptr_next)
        else $error("pre-increment address is not the updated pointer");
    AST_TBL_ADDR: assert property (req_valid && req_table |=> prog_valid && prog_addr[15:0] == $past(req_ptr))
        else $error("table address low word wrong");
    AST_TBL_CFG: assert property (req_valid && req_table |=> prog_cfg == prog_addr[23])
        else $error("configuration select disagrees with page MSB");
    AST_TBL_DIR: assert property (req_valid && req_table |=> prog_write == $past(req_write) && prog_hi_byte == $past(req_hi_byte))
        else $error("table direction or byte select wrong");
    AST_VIS_ADDR: assert property (req_valid && !req_table && req_ptr[15] && !req_write |=> prog_valid && prog_low_word && !prog_addr[23] && prog_addr[14:0] == 15'($past(req_ptr)))
        else $error("visibility address wrong");
    AST_VIS_WR: assert property (req_valid && !req_table && req_ptr[15] && req_write |=> prog_wr_reject && !prog_write)
        else $error("visibility write not refused");
endmodule
bind agu_top agu_chk u_chk (.*);

// ===== verif/agu_prog_model.sv
/*
 Program memory side: counts writes that really reach the array.
 Assumes the address unit's program bus ports and its clock.
*/
module agu_prog_model
(
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic prog_valid,
    input  wire logic prog_write,
    input  wire logic prog_wr_reject,
    output int        prog_writes
);
    timeunit 1ns;
    timeprecision 1ns;
    // Refused visibility writes never reach the array
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            prog_writes <= 0;
        else if (prog_valid && prog_write && !prog_wr_reject)
            prog_writes <= prog_writes + 1;
    end
endmodule

// ===== verif/testbench.sv
/*
 Self-checking bench for agu_top with a program memory model.
 Assumes the package constants and the one-cycle answer of the bus.
*/
module testbench
    import agu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              core_clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0]       avs_writedata = '0, avs_readdata;
    logic [3:0]        avs_byteenable = 4'hF;
    logic              req_valid = 1'b0, req_write = 1'b0, req_byte = 1'b0, req_table = 1'b0, req_hi_byte = 1'b0;
    logic [2:0]        req_mode = 3'h0;
    logic [3:0]        req_wreg = 4'h0;
    logic [DATA_W-1:0] req_ptr = '0, wr_ea, wr_ptr_next;
    logic              wr_valid, wr_rev_active, rd_modulo_en, prog_valid, prog_write, prog_cfg;
    logic              prog_hi_byte, prog_low_word, prog_wr_reject;
    logic [PROG_W-1:0] prog_addr;
    int                mismatches = 0, comparisons = 0, cycles = 0, prog_writes;

    agu_top DUT (.*);
    agu_prog_model u_prog (.*);

    always #20 core_clk = ~core_clk;

    task automatic conclude();
        if (mismatches == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard: the whole run needs about 1200 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
        @(posedge core_clk);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, wr, !wr, 16'h0000, d};
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge core_clk);
        q = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
    endtask

    task automatic req(input logic w, b, input logic [2:0] m, input logic [3:0] r, input logic [15:0] p,
                       input logic t, h);
        @(posedge core_clk);
        {req_write, req_byte, req_mode, req_wreg, req_ptr, req_table, req_hi_byte, req_valid} <= {w, b, m, r, p, t, h, 1'b1};
        @(posedge core_clk);
        req_valid <= 1'b0;
        #1;
    endtask

    function automatic logic [15:0] rev(input logic [15:0] x);
        for (int i = 0; i < 16; i++)
            rev[i] = x[15-i];
    endfunction

    // Carry runs toward the LSB: add in reversed order, then flip back
    function automatic logic [15:0] rcadd(input logic [15:0] p, input logic [14:0] m);
        return rev(rev(p) + rev({m, 1'b0})) & 16'hFFFE;
    endfunction

    initial
    begin
        logic [31:0] q;
        logic [14:0] m;
        logic [15:0] p, pg, e;
        logic [3:0]  sel;
        logic [2:0]  other[4];
        int          k;
        other = '{MODE_DIRECT, MODE_IND, MODE_POSTDEC, MODE_PREDEC};
        void'($urandom(37));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        bus(1'b1, 4'h2, 16'hFFFF, q);
        for (int a = 0; a < 16; a += 2)
        begin
            bus(1'b0, 4'(a), 16'h0000, q);
            chk("reset_read", 32'h0, q);
        end
        repeat (30)
        begin
            sel = 4'($urandom_range(14));
            k = $urandom_range(12);
            m = 15'(1 << k);
            bus(1'b1, OFS_MODULO, {1'b1, 3'b000, sel, 8'h00}, q);
            bus(1'b1, OFS_REVERSE, {1'b1, m}, q);
            bus(1'b0, OFS_REVERSE, 16'h0000, q);
            chk("reverse_reg", {16'h0000, 1'b1, m}, q);
            @(posedge core_clk);
            p = ((16'($urandom) << (k + 2)) & 16'h7FFF) | 16'($urandom_range(1));
            for (int s = 0; s < 4; s++)
            begin
                e = rcadd(p, m);
                req(1'b1, 1'b0, s[0] ? MODE_PREINC : MODE_POSTINC, sel, p, 1'b0, 1'b0);
                chk("rev_active", 32'h3, {wr_valid, wr_rev_active});
                chk("ptr_next", e, wr_ptr_next);
                chk("rev_ea", s[0] ? e : p & 16'hFFFE, wr_ea);
                p = e;
            end
            req(1'b1, 1'b1, MODE_POSTINC, sel, p, 1'b0, 1'b0);
            chk("byte_rev", 32'h0, 32'(wr_rev_active));
            chk("byte_ea", p, wr_ea);
            foreach (other[j])
            begin
                req(1'b1, 1'b0, other[j], sel, p, 1'b0, 1'b0);
                chk("mode_rev", 32'h0, 32'(wr_rev_active));
            end
            req(1'b1, 1'b0, MODE_PREINC, sel ^ 4'h1, p, 1'b0, 1'b0);
            chk("wreg_rev", 32'h0, 32'(wr_rev_active));
            req(1'b0, 1'b0, MODE_POSTINC, sel, p, 1'b0, 1'b0);
            chk("read_modulo", 32'h1, {wr_valid, wr_rev_active, rd_modulo_en});
        end
        bus(1'b1, OFS_MODULO, {4'h0, STACK_SEL, 8'h00}, q);
        req(1'b1, 1'b0, MODE_PREINC, STACK_SEL, 16'h0100, 1'b0, 1'b0);
        chk("stack_rev", 32'h0, 32'(wr_rev_active));
        for (int i = 0; i < 20; i++)
        begin
            pg = {8'h00, i[2], 7'($urandom)};
            p = 16'($urandom);
            bus(1'b1, OFS_TBLPAGE, pg, q);
            req(i[0], 1'b0, MODE_IND, 4'h0, p, 1'b1, i[1]);
            chk("tbl_addr", {pg[7:0], p}, prog_addr);
            chk("tbl_cfg", pg[7], prog_cfg);
            chk("tbl_dir", {i[0], i[1]}, {prog_write, prog_hi_byte});
        end
        for (int i = 0; i < 16; i++)
        begin
            pg = 16'($urandom_range(255));
            p = 16'($urandom) | 16'h8000;
            bus(1'b1, OFS_VISPAGE, pg, q);
            bus(1'b0, OFS_VISPAGE, 16'h0000, q);
            chk("vis_reg", pg, q);
            req(i[0], 1'b0, MODE_IND, 4'h0, p, 1'b0, 1'b0);
            if (i[0])
                chk("vis_reject", 32'h1, {prog_write, prog_wr_reject});
            else
                chk("vis_addr", {1'b1, 1'b0, pg[7:0], p[14:0]}, {prog_low_word, prog_addr});
        end
        chk("prog_writes", 32'd10, prog_writes);
        conclude();
    end
endmodule
